// file: ppp_buf.sv
// Purpose: two-entry buffer for program requests
// Assumes: single clock, valid/ready on both sides
// Notes:   e0 is always the head entry
`timescale 1ns/100ps
`include "ppp_defs.svh"

module ppp_buf
(
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  input  wire logic [`PPP_REQ_W-1:0] in_data_i,
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i,
  output logic [`PPP_REQ_W-1:0]      out_data_o
);

  ppp_pkg::ppp_buf_st_t st;
  ppp_pkg::ppp_buf_st_t next_st;
  logic                 push;
  logic                 pop;

  assign in_ready_o  = (st.cnt != 2'h2);
  assign out_valid_o = (st.cnt != 2'h0);
  assign out_data_o  = st.e0;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    next_st = st;
    if (pop)
    begin
      next_st.e0 = st.e1;
    end
    if (push)
    begin
      if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop))
      begin
        next_st.e0 = in_data_i;
      end
      else
      begin
        next_st.e1 = in_data_i;
      end
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  property p_no_overflow;
    @(posedge clk_i) disable iff (!arst_n_i)
    st.cnt <= 2'h2;
  endproperty
  a_no_overflow : assert property (p_no_overflow)
    else $error("buffer count out of range");

endmodule

// file: ppp_core.sv
// Purpose: device side of the parallel programming port
// Assumes: all pins synchronous to clk_i; flash array answers rd_data_i
//          combinationally for rd_addr_o
// Notes:   program requests leave through a two-entry buffer
`timescale 1ns/100ps
`include "ppp_defs.svh"

module ppp_core
#(
  parameter logic [`PPP_CNT_W-1:0] PROG_CYCLES = `PPP_CNT_W'(`PPP_PROG_CYCLES),
  parameter logic [7:0]            SIG_BYTE0   = `PPP_SIG_BYTE0,  // Arbitrary value
  parameter logic [7:0]            SIG_BYTE1   = `PPP_SIG_BYTE1,  // Arbitrary value
  parameter logic [7:0]            SIG_BYTE2   = `PPP_SIG_BYTE2   // Arbitrary value
)
(
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  action_select_hi_i,
  input  wire logic                  action_select_lo_i,
  input  wire logic                  byte_select_i,
  input  wire logic                  load_strobe_i,
  input  wire logic                  write_strobe_n_i,
  input  wire logic                  output_enable_n_i,
  input  wire logic [7:0]            data_i,
  output logic [7:0]                 data_o,
  output logic                       data_oe_o,
  output logic                       ready_busy_o,
  output logic [`PPP_ADDR_W-1:0]     rd_addr_o,
  input  wire logic [15:0]           rd_data_i,
  output logic                       pg_valid_o,
  input  wire logic                  pg_ready_i,
  output logic [`PPP_REQ_W-1:0]      pg_req_o
);

  // ****************************************************************
  // State and strobe edges
  // ****************************************************************
  ppp_pkg::ppp_core_t st;
  ppp_pkg::ppp_core_t next_st;
  logic [1:0]         act;
  logic               ls_rise;
  logic               wr_fall;
  logic               idle;
  logic               start;
  logic               buf_in_ready;
  logic               reading;
  logic [7:0]         sig_byte;

  assign act     = {action_select_hi_i, action_select_lo_i};
  assign ls_rise = load_strobe_i && !st.ls_q;
  assign wr_fall = st.wr_q && !write_strobe_n_i;
  assign idle    = (st.state == ppp_pkg::PPP_IDLE);
  // Buffer room is checked too so a stalled sink never drops a request
  assign start   = wr_fall && idle && buf_in_ready;

  assign ready_busy_o = idle;
  assign data_o       = st.dout;
  assign data_oe_o    = st.doe;
  assign rd_addr_o    = {st.addr_hi[0], st.addr_lo};
  assign reading      = (st.cmd == `PPP_CMD_READ_FLASH) || (st.cmd == `PPP_CMD_READ_SIG);

  always_comb
  begin
    unique case (st.addr_lo)
      8'h00: sig_byte = SIG_BYTE0;
      8'h01: sig_byte = SIG_BYTE1;
      8'h02: sig_byte = SIG_BYTE2;
      default: sig_byte = 8'hFF;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_st      = st;
    next_st.ls_q = load_strobe_i;
    next_st.wr_q = write_strobe_n_i;

    // Loads are frozen while a byte programs
    if (ls_rise && idle)
    begin
      unique case (act)
        `PPP_ACT_CMD:  next_st.cmd = data_i;
        `PPP_ACT_ADDR:
        begin
          if (byte_select_i)
          begin
            next_st.addr_hi = data_i;
          end
          else
          begin
            next_st.addr_lo = data_i;
          end
        end
        `PPP_ACT_DATA:
        begin
          if (byte_select_i)
          begin
            next_st.data_hi = data_i;
          end
          else
          begin
            next_st.data_lo = data_i;
          end
        end
        default: next_st.cmd = st.cmd;
      endcase
    end

    unique case (st.state)
      ppp_pkg::PPP_IDLE:
      begin
        if (start)
        begin
          next_st.state = ppp_pkg::PPP_PROG;
          next_st.cnt   = PROG_CYCLES - `PPP_CNT_W'(1);
        end
      end
      ppp_pkg::PPP_PROG:
      begin
        if (st.cnt == '0)
        begin
          next_st.state = buf_in_ready ? ppp_pkg::PPP_IDLE : ppp_pkg::PPP_DRAIN;
        end
        else
        begin
          next_st.cnt = st.cnt - `PPP_CNT_W'(1);
        end
      end
      ppp_pkg::PPP_DRAIN:
      begin
        if (buf_in_ready)
        begin
          next_st.state = ppp_pkg::PPP_IDLE;
        end
      end
    endcase

    // Read path; only read commands may drive the bus
    next_st.doe = !output_enable_n_i && reading;
    if (st.cmd == `PPP_CMD_READ_SIG)
    begin
      next_st.dout = sig_byte;
    end
    else
    begin
      next_st.dout = byte_select_i ? rd_data_i[15:8] : rd_data_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st       <= '0;
      st.cmd   <= `PPP_CMD_RESET;
      st.state <= ppp_pkg::PPP_IDLE;
      st.ls_q  <= 1'b0;
      st.wr_q  <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Program request buffer
  // ****************************************************************
  ppp_buf u_buf
  (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (start),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({st.cmd, rd_addr_o, byte_select_i,
                   byte_select_i ? st.data_hi : st.data_lo}),
    .out_valid_o (pg_valid_o),
    .out_ready_i (pg_ready_i),
    .out_data_o  (pg_req_o)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [`PPP_CNT_W-1:0] busy_len;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      busy_len <= '0;
    end
    else if (ready_busy_o)
    begin
      busy_len <= '0;
    end
    else
    begin
      busy_len <= busy_len + `PPP_CNT_W'(1);
    end
  end

  property p_cmd_load;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ls_rise && idle && act == `PPP_ACT_CMD) |=> (st.cmd == $past(data_i));
  endproperty
  a_cmd_load : assert property (p_cmd_load)
    else $error("command not latched");

  property p_addr_hi;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ls_rise && idle && act == `PPP_ACT_ADDR && byte_select_i)
      |=> (st.addr_hi == $past(data_i)) && $stable(st.addr_lo);
  endproperty
  a_addr_hi : assert property (p_addr_hi)
    else $error("address high byte not latched");

  property p_addr_lo;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ls_rise && idle && act == `PPP_ACT_ADDR && !byte_select_i)
      |=> (st.addr_lo == $past(data_i)) && $stable(st.addr_hi);
  endproperty
  a_addr_lo : assert property (p_addr_lo)
    else $error("address low byte not latched");

  property p_data_lo;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ls_rise && idle && act == `PPP_ACT_DATA && !byte_select_i)
      |=> (st.data_lo == $past(data_i));
  endproperty
  a_data_lo : assert property (p_data_lo)
    else $error("data low byte not latched");

  property p_data_hi;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ls_rise && idle && act == `PPP_ACT_DATA && byte_select_i)
      |=> (st.data_hi == $past(data_i));
  endproperty
  a_data_hi : assert property (p_data_hi)
    else $error("data high byte not latched");

  property p_wr_lo;
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_fall && ready_busy_o && buf_in_ready && !byte_select_i)
      |=> !ready_busy_o ##0 (pg_valid_o);
  endproperty
  a_wr_lo : assert property (p_wr_lo)
    else $error("low byte write did not start");

  property p_wr_hi;
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_fall && ready_busy_o && buf_in_ready && byte_select_i) |=> !ready_busy_o [*3];
  endproperty
  a_wr_hi : assert property (p_wr_hi)
    else $error("high byte write did not go busy");

  property p_hold_busy;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!ready_busy_o && !$past(ready_busy_o)) |-> $stable(st.cmd) && $stable(rd_addr_o);
  endproperty
  a_hold_busy : assert property (p_hold_busy)
    else $error("command or address changed while busy");

  property p_read_lo;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!output_enable_n_i && !byte_select_i && st.cmd == `PPP_CMD_READ_FLASH)
      |=> data_oe_o && (data_o == $past(rd_data_i[7:0]));
  endproperty
  a_read_lo : assert property (p_read_lo)
    else $error("flash low byte not driven");

  property p_read_hi;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!output_enable_n_i && byte_select_i && st.cmd == `PPP_CMD_READ_FLASH)
      |=> data_oe_o && (data_o == $past(rd_data_i[15:8]));
  endproperty
  a_read_hi : assert property (p_read_hi)
    else $error("flash high byte not driven");

  property p_sig;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!output_enable_n_i && st.cmd == `PPP_CMD_READ_SIG && st.addr_lo == 8'h01)
      |=> data_oe_o && (data_o == SIG_BYTE1);
  endproperty
  a_sig : assert property (p_sig)
    else $error("signature byte not driven");

  property p_release;
    @(posedge clk_i) disable iff (!arst_n_i)
    output_enable_n_i |=> !data_oe_o;
  endproperty
  a_release : assert property (p_release)
    else $error("bus not released");

  property p_busy_len;
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(ready_busy_o) |-> (busy_len >= PROG_CYCLES);
  endproperty
  a_busy_len : assert property (p_busy_len)
    else $error("busy time too short");

  // A late strobe must neither restart nor stall the program count
  property p_ignore_wr;
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_fall && st.state == ppp_pkg::PPP_PROG && st.cnt != '0)
      |=> (st.state == ppp_pkg::PPP_PROG) && (st.cnt == $past(st.cnt) - `PPP_CNT_W'(1));
  endproperty
  a_ignore_wr : assert property (p_ignore_wr)
    else $error("write accepted while busy");

  c_program   : cover property (@(posedge clk_i) disable iff (!arst_n_i)
    start ##1 !ready_busy_o [*8]);
  c_read      : cover property (@(posedge clk_i) disable iff (!arst_n_i)
    data_oe_o && st.cmd == `PPP_CMD_READ_FLASH);
  c_drain     : cover property (@(posedge clk_i) disable iff (!arst_n_i)
    st.state == ppp_pkg::PPP_DRAIN);
  c_sig_read  : cover property (@(posedge clk_i) disable iff (!arst_n_i)
    data_oe_o && st.cmd == `PPP_CMD_READ_SIG);

endmodule

// file: ppp_defs.svh
// Purpose: constants of the parallel programming port
// Assumes: 10 MHz clock, all pins synchronous to it
// Notes:   field codes, signature bytes, reset values, timing counts and request widths
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

// ****************************************************************
// Action select codes
// ****************************************************************
`define PPP_ACT_ADDR      2'h0
`define PPP_ACT_DATA      2'h1
`define PPP_ACT_CMD       2'h2

// ****************************************************************
// Command codes
// ****************************************************************
`define PPP_CMD_READ_FLASH 8'h02
`define PPP_CMD_READ_SIG   8'h08
`define PPP_CMD_RESET      8'h00

// ****************************************************************
// Signature window and default bytes (values arbitrary)
// ****************************************************************
`define PPP_SIG_LAST      8'h02
`define PPP_SIG_BYTE0     8'h5A
`define PPP_SIG_BYTE1     8'h3C
`define PPP_SIG_BYTE2     8'h11

// ****************************************************************
// Timing
// ****************************************************************
`define PPP_CLK_MHZ       10
`define PPP_T_PROG_US     700
`define PPP_PROG_CYCLES   (`PPP_T_PROG_US * `PPP_CLK_MHZ)
`define PPP_CNT_W         16

// ****************************************************************
// Program request layout
// ****************************************************************
`define PPP_ADDR_W        9
`define PPP_REQ_W         26

`endif

// file: ppp_pkg.sv
// Purpose: types shared by the programming port modules
// Assumes: widths from ppp_defs.svh
// Notes:   state records are registered whole
`include "ppp_defs.svh"

package ppp_pkg;

  typedef enum logic [1:0] {PPP_IDLE, PPP_PROG, PPP_DRAIN} ppp_state_t;

  typedef struct packed {
    logic [7:0]           cmd;
    logic [7:0]           addr_hi;
    logic [7:0]           addr_lo;
    logic [7:0]           data_lo;
    logic [7:0]           data_hi;
    logic [`PPP_CNT_W-1:0] cnt;
    ppp_state_t           state;
    logic                 ls_q;
    logic                 wr_q;
    logic [7:0]           dout;
    logic                 doe;
  } ppp_core_t;

  typedef struct packed {
    logic [`PPP_REQ_W-1:0] e0;
    logic [`PPP_REQ_W-1:0] e1;
    logic [1:0]            cnt;
  } ppp_buf_st_t;

endpackage

// file: ppp_sink_model.sv
// Purpose: flash array and program-request sink beside the port
// Assumes: single clock, word answered in the same cycle as the address
// Notes:   stall_i holds off pg_ready_o to let the request buffer fill
`timescale 1ns/100ps
`include "ppp_defs.svh"

module ppp_sink_model
(
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic [`PPP_ADDR_W-1:0] rd_addr_i,
  output logic [15:0]                rd_data_o,
  input  wire logic                  pg_valid_i,
  input  wire logic [`PPP_REQ_W-1:0] pg_req_i,
  input  wire logic                  stall_i,
  output logic                       pg_ready_o,
  output logic [`PPP_REQ_W-1:0]      last_req_o,
  output logic [7:0]                 n_req_o
);
  // ****************************************************************
  // Array and sink
  // ****************************************************************
  // Both bytes differ per address so a swapped byte shows
  assign rd_data_o  = {~rd_addr_i[7:0], rd_addr_i[7:0] ^ {7'h00, rd_addr_i[8]}};
  assign pg_ready_o = !stall_i;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      last_req_o <= '0;
      n_req_o    <= 8'h00;
    end
    else if (pg_valid_i && pg_ready_o)
    begin
      last_req_o <= pg_req_i;
      n_req_o    <= n_req_o + 8'h01;
    end
  end
endmodule

// file: test_parallel_program_port.sv
// Purpose: self-checking bench of the programming port core
// Assumes: PROG_CYCLES shortened to 20
// Notes:   bench plays the programmer on the pins
`timescale 1ns/100ps
`include "ppp_defs.svh"

module test_parallel_program_port;
  localparam int PROG = 20;
  localparam int FUSE_LOW  = 10000;  // 1.0 ms at 10 MHz
  localparam int ERASE_LOW = 50000;  // 5.0 ms at 10 MHz
  logic                   clk_i = 1'b0;
  logic                   arst_n = 1'b0;
  logic [1:0]             act = 2'h3;
  logic                   bs = 1'b0;
  logic                   ls = 1'b0;
  logic                   wr_n = 1'b1;
  logic                   oe_n = 1'b1;
  logic                   stall = 1'b0;
  logic [7:0]             dbus = 8'h00;
  logic [7:0]             data_o;
  logic                   data_oe_o;
  logic                   ready_busy_o;
  logic [`PPP_ADDR_W-1:0] rd_addr;
  logic [15:0]            rd_data;
  logic                   pg_valid;
  logic                   pg_ready;
  logic [`PPP_REQ_W-1:0]  pg_req;
  logic [`PPP_REQ_W-1:0]  last_req;
  logic [7:0]             sink_n;
  wire  [7:0]             data_bus = data_oe_o ? data_o : dbus;
  int                     n_fail = 0;
  int                     n_compared = 0;

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  ppp_core #(.PROG_CYCLES(16'(PROG))) ppp_core_inst (.clk_i(clk_i), .arst_n_i(arst_n),
    .action_select_hi_i(act[1]), .action_select_lo_i(act[0]), .byte_select_i(bs),
    .load_strobe_i(ls), .write_strobe_n_i(wr_n), .output_enable_n_i(oe_n),
    .data_i(data_bus), .data_o(data_o), .data_oe_o(data_oe_o), .ready_busy_o(ready_busy_o),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data), .pg_valid_o(pg_valid),
    .pg_ready_i(pg_ready), .pg_req_o(pg_req));

  ppp_sink_model ppp_sink_model_inst (.clk_i(clk_i), .arst_n_i(arst_n), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .pg_valid_i(pg_valid), .pg_req_i(pg_req), .stall_i(stall),
    .pg_ready_o(pg_ready), .last_req_o(last_req), .n_req_o(sink_n));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_vec(input string nm, input logic [25:0] e, input logic [25:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Strobe low two cycles between pulses; the port needs at least one
  task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
    @(posedge clk_i);
    act  <= a;
    bs   <= b;
    dbus <= d;
    ls   <= 1'b1;
    @(posedge clk_i);
    ls <= 1'b0;
    @(posedge clk_i);
    act <= 2'h3;
  endtask

  task automatic wr(input logic b);
    @(posedge clk_i);
    bs   <= b;
    wr_n <= 1'b0;
    @(posedge clk_i);
    wr_n <= 1'b1;
  endtask

  // Counts busy cycles; returns zero if busy has not started by the fifth cycle, gives up if it never ends
  task automatic wait_rdy(output int n);
    n = 0;
    for (int i = 0; i < 500; i++)
    begin
      @(negedge clk_i);
      if (ready_busy_o === 1'b1 && (n > 0 || i > 3))
        return;
      if (ready_busy_o === 1'b0)
        n++;
    end
    n_fail++;
    $display("mismatch ready_busy expected 1 seen 0");
    stop_test();
  endtask

  task automatic read_byte(input logic b, input string nm, input logic [7:0] e);
    @(posedge clk_i);
    oe_n <= 1'b0;
    bs   <= b;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk_vec(nm, 26'(e), 26'(data_bus));
    @(posedge clk_i);
    oe_n <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge clk_i);
    chk_bit("ready_busy", 1'b1, ready_busy_o);
    chk_bit("data_oe", 1'b0, data_oe_o);
    chk_bit("pg_valid", 1'b0, pg_valid);
    $display("test reset done");
  endtask

  task automatic t_flash_read();
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_READ_FLASH);
    load(`PPP_ACT_ADDR, 1'b1, 8'h01);
    load(`PPP_ACT_ADDR, 1'b0, 8'hA7);
    @(negedge clk_i);
    chk_vec("rd_addr", 26'h00001A7, 26'(rd_addr));
    read_byte(1'b0, "flash_low", 8'hA6);
    read_byte(1'b1, "flash_high", 8'h58);
    @(negedge clk_i);
    chk_bit("data_oe", 1'b0, data_oe_o);
    $display("test flash read done");
  endtask

  task automatic t_sig();
    logic [7:0] e [4];
    e = '{`PPP_SIG_BYTE0, `PPP_SIG_BYTE1, `PPP_SIG_BYTE2, 8'hFF};
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_READ_SIG);
    for (int k = 0; k < 4; k++)
    begin
      load(`PPP_ACT_ADDR, 1'b0, 8'(k));
      read_byte(1'b0, "signature", e[k]);
    end
    $display("test signature done");
  endtask

  task automatic t_prog();
    int n;
    logic [7:0] n0;
    load(`PPP_ACT_CMD, 1'b0, 8'h40);
    load(`PPP_ACT_ADDR, 1'b1, 8'h00);
    load(`PPP_ACT_ADDR, 1'b0, 8'h12);
    load(`PPP_ACT_DATA, 1'b0, 8'h3C);
    load(`PPP_ACT_DATA, 1'b1, 8'hC5);
    // A command outside the read set never drives the bus
    @(posedge clk_i);
    oe_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit("data_oe", 1'b0, data_oe_o);
    @(posedge clk_i);
    oe_n <= 1'b1;
    n0 = sink_n;
    wr(1'b0);
    wait_rdy(n);
    chk_vec("busy_cycles", 26'(PROG), 26'(n));
    chk_vec("request", {8'h40, 9'h012, 1'b0, 8'h3C}, last_req);
    wr(1'b1);
    wr(1'b0);
    load(`PPP_ACT_ADDR, 1'b0, 8'h99);
    wait_rdy(n);
    chk_vec("request", {8'h40, 9'h012, 1'b1, 8'hC5}, last_req);
    chk_vec("requests", 26'(n0 + 8'h02), 26'(sink_n));
    chk_vec("rd_addr", 26'h0000012, 26'(rd_addr));
    $display("test program done");
  endtask

  task automatic t_stall();
    int n;
    logic [7:0] n0;
    n0 = sink_n;
    @(posedge clk_i);
    stall <= 1'b1;
    wr(1'b0);
    wait_rdy(n);
    chk_vec("busy_cycles", 26'(PROG), 26'(n));
    wr(1'b1);
    repeat (3 * PROG) @(negedge clk_i);
    // Full buffer holds the port busy past the program time
    chk_bit("ready_busy", 1'b0, ready_busy_o);
    chk_vec("requests", 26'(n0), 26'(sink_n));
    @(posedge clk_i);
    stall <= 1'b0;
    wait_rdy(n);
    chk_vec("requests", 26'(n0 + 8'h02), 26'(sink_n));
    chk_vec("request", {8'h40, 9'h012, 1'b1, 8'hC5}, last_req);
    $display("test stall done");
  endtask

  // Strobe held low for len cycles must start exactly one program
  task automatic long_wr(input int len);
    logic [7:0] n0;
    n0 = sink_n;
    @(posedge clk_i);
    bs   <= 1'b0;
    wr_n <= 1'b0;
    repeat (len) @(posedge clk_i);
    wr_n <= 1'b1;
    @(negedge clk_i);
    chk_bit("ready_busy", 1'b1, ready_busy_o);
    chk_vec("requests", 26'(n0 + 8'h01), 26'(sink_n));
    chk_vec("request", {8'h40, 9'h012, 1'b0, 8'h3C}, last_req);
  endtask

  task automatic t_long_wr();
    long_wr(FUSE_LOW);
    long_wr(ERASE_LOW);
    $display("test long strobe done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    arst_n <= 1'b1;
    t_reset();
    t_flash_read();
    t_sig();
    t_prog();
    t_stall();
    t_long_wr();
    stop_test();
  end
endmodule
